// file: node_switch_route_config.sv
// switch configuration registers, message responder and route decision
`default_nettype none
module node_switch_route_config #(
  parameter logic [7:0] LINK_COUNT     = 8'h04,
  parameter logic [7:0] CORE_COUNT     = 8'h01,
  parameter logic [7:0] LINKS_PER_CORE = 8'h04
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // configuration message request
  input  wire logic        cfg_req_valid,
  input  wire logic        cfg_req_write,
  input  wire logic [15:0] cfg_req_reg,
  input  wire logic [31:0] cfg_req_wdata,
  output var  logic        cfg_req_ready,
  // configuration response tokens
  output var  logic        cfg_rsp_valid,
  output var  logic        cfg_rsp_ctrl,
  output var  logic [31:0] cfg_rsp_word,
  // packet routing
  input  wire logic        pkt_valid,
  input  wire logic [15:0] pkt_dest,
  output var  logic        route_valid,
  output var  logic        route_local,
  output var  logic [3:0]  route_dir,
  // switch state
  output var  logic        one_byte_header,
  output var  logic [31:0] clk_mult_setting,
  output var  logic        tile_reset,
  // debug
  input  wire logic        node_in_debug,
  input  wire logic        debug_n_i,
  output var  logic        debug_n_o,
  output var  logic        debug_n_oe,
  output var  logic        debug_call_trap
);
  import node_switch_pkg::*;

  typedef struct packed {
    logic [15:0] node_id;
    logic        wr_lock;
    logic        cm_lock;
    logic        hdr_mode;
    logic [31:0] clk_mult;
    logic [63:0] dirs;
    logic        dbg_trap_en;
    logic        dbg_pull_en;
    rsp_state_t  rsp_st;
    logic [31:0] rd_data;
    logic        ready;
    logic        rsp_valid;
    logic        rsp_ctrl;
    logic [31:0] rsp_word;
    logic        tile_rst;
    logic [1:0]  dbg_sync;
    logic        dbg_prev;
    logic        trap;
    logic        n_oe;
    logic        route_valid;
    logic        route_local;
    logic [3:0]  route_dir;
  } state_t;

  state_t s_q;
  state_t s_d;

  route_lookup_if lk ();

  assign lk.dest    = pkt_dest;
  assign lk.node_id = s_q.node_id;
  assign lk.dirs    = s_q.dirs;

  route_lookup #(
    .IDW (NODE_ID_W)
  ) u_lookup (
    .lk (lk)
  );

  logic        acc;
  logic        mapped;
  logic        wr_ok;
  logic [31:0] desc_word;
  logic [31:0] rd_mux;

  assign desc_word = {8'h00, LINK_COUNT, CORE_COUNT, LINKS_PER_CORE};
  assign acc       = cfg_req_valid && s_q.ready;

  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (cfg_req_reg)
      REG_DESCRIPTION: rd_mux = desc_word;
      REG_SWITCH_CFG:  rd_mux = {s_q.wr_lock, 22'h000000, s_q.cm_lock, 7'h00, s_q.hdr_mode};
      REG_NODE_ID:     rd_mux = {16'h0000, s_q.node_id};
      REG_CLK_MULT:    rd_mux = s_q.clk_mult;
      REG_DIRS_LOW:    rd_mux = s_q.dirs[31:0];
      REG_DIRS_HIGH:   rd_mux = s_q.dirs[63:32];
      REG_DEBUG_PIN:   rd_mux = {30'h00000000, s_q.dbg_trap_en, s_q.dbg_pull_en};
      default:         mapped = 1'b0;
    endcase
    wr_ok = mapped && !s_q.wr_lock && (cfg_req_reg != REG_DESCRIPTION)
            && !(s_q.cm_lock && (cfg_req_reg == REG_CLK_MULT));
  end

  always_comb
  begin
    s_d             = s_q;
    s_d.tile_rst    = 1'b0;
    s_d.trap        = 1'b0;
    s_d.rsp_valid   = 1'b0;
    s_d.rsp_ctrl    = 1'b0;
    s_d.rsp_word    = 32'h0000_0000;
    // first stage feeds only the second
    s_d.dbg_sync    = {s_q.dbg_sync[0], debug_n_i};
    s_d.dbg_prev    = s_q.dbg_sync[1];
    s_d.trap        = s_q.dbg_trap_en && s_q.dbg_prev && !s_q.dbg_sync[1];
    s_d.n_oe        = s_q.dbg_pull_en && node_in_debug;
    s_d.route_valid = pkt_valid;
    if (pkt_valid)
    begin
      s_d.route_local = lk.local_hit;
      s_d.route_dir   = lk.local_hit ? 4'h0 : lk.dir;
    end
    case (s_q.rsp_st)
      RSP_IDLE:
      begin
        if (acc)
        begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_ctrl  = 1'b1;
          s_d.ready     = 1'b0;
          s_d.rd_data   = rd_mux;
          if (cfg_req_write)
          begin
            s_d.rsp_word = wr_ok ? TOK_ACK : TOK_NACK;
            s_d.rsp_st   = RSP_END;
            if (wr_ok)
            begin
              case (cfg_req_reg)
                // header mode; locks are set-only until reset
                REG_SWITCH_CFG:
                begin
                  s_d.wr_lock  = cfg_req_wdata[CFG_WR_LOCK_BIT];
                  s_d.cm_lock  = s_q.cm_lock | cfg_req_wdata[CFG_CM_LOCK_BIT];
                  s_d.hdr_mode = cfg_req_wdata[CFG_HDR_BIT];
                end
                REG_NODE_ID: s_d.node_id = cfg_req_wdata[NODE_ID_W-1:0];
                REG_CLK_MULT:
                begin
                  s_d.clk_mult = cfg_req_wdata;
                  s_d.tile_rst = 1'b1;
                end
                REG_DIRS_LOW: s_d.dirs[31:0] = cfg_req_wdata;
                REG_DIRS_HIGH: s_d.dirs[63:32] = cfg_req_wdata;
                REG_DEBUG_PIN:
                begin
                  s_d.dbg_trap_en = cfg_req_wdata[DBG_TRAP_BIT];
                  s_d.dbg_pull_en = cfg_req_wdata[DBG_PULL_BIT];
                end
                default: s_d.node_id = s_q.node_id;
              endcase
            end
          end
          else
          begin
            s_d.rsp_word = mapped ? TOK_ACK : TOK_NACK;
            s_d.rsp_st   = mapped ? RSP_DATA : RSP_END;
          end
        end
      end
      RSP_DATA:
      begin
        s_d.rsp_valid = 1'b1;
        s_d.rsp_word  = s_q.rd_data;
        s_d.rsp_st    = RSP_END;
      end
      RSP_END:
      begin
        s_d.rsp_valid = 1'b1;
        s_d.rsp_ctrl  = 1'b1;
        s_d.rsp_word  = TOK_END;
        s_d.rsp_st    = RSP_IDLE;
        s_d.ready     = 1'b1;
      end
      default:
      begin
        s_d.rsp_st = RSP_IDLE;
        s_d.ready  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q          <= '0;
      s_q.node_id  <= NODE_ID_RST;
      s_q.dirs     <= {DIRS_RST, DIRS_RST};
      s_q.clk_mult <= CLK_MULT_RST;
      s_q.rsp_st   <= RSP_IDLE;
      s_q.ready    <= 1'b1;
      s_q.dbg_sync <= 2'h3;
      s_q.dbg_prev <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign cfg_req_ready    = s_q.ready;
  assign cfg_rsp_valid    = s_q.rsp_valid;
  assign cfg_rsp_ctrl     = s_q.rsp_ctrl;
  assign cfg_rsp_word     = s_q.rsp_word;
  assign route_valid      = s_q.route_valid;
  assign route_local      = s_q.route_local;
  assign route_dir        = s_q.route_dir;
  assign one_byte_header  = s_q.hdr_mode;
  assign clk_mult_setting = s_q.clk_mult;
  assign tile_reset       = s_q.tile_rst;
  // open drain: only ever drives low
  assign debug_n_o        = 1'b0;
  assign debug_n_oe       = s_q.n_oe;
  assign debug_call_trap  = s_q.trap;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic wr_acc;
  assign wr_acc = acc && cfg_req_write;

  sequence s_ok_reply;
    cfg_rsp_valid && cfg_rsp_ctrl && cfg_rsp_word == 32'h0000_0003;
  endsequence
  sequence s_fail_reply;
    cfg_rsp_valid && cfg_rsp_ctrl && cfg_rsp_word == 32'h0000_0004;
  endsequence
  sequence s_end_reply;
    cfg_rsp_valid && cfg_rsp_ctrl && cfg_rsp_word == 32'h0000_0001;
  endsequence

  property p_locked_write_kept;
    wr_acc && s_q.wr_lock |=> $stable(s_q.node_id) && $stable(s_q.dirs) && $stable(s_q.clk_mult);
  endproperty
  a_locked_write_kept: assert property (p_locked_write_kept)
    else $error("locked write changed state");

  property p_cm_lock;
    wr_acc && s_q.cm_lock && cfg_req_reg == REG_CLK_MULT
      |=> $stable(clk_mult_setting) && !tile_reset;
  endproperty
  a_cm_lock: assert property (p_cm_lock) else $error("multiplier changed while locked");

  property p_tile_reset;
    wr_acc && wr_ok && cfg_req_reg == REG_CLK_MULT
      |=> tile_reset && clk_mult_setting == $past(cfg_req_wdata);
  endproperty
  a_tile_reset: assert property (p_tile_reset)
    else $error("no tile reset after multiplier write");

  property p_write_reply;
    wr_acc && wr_ok |=> s_ok_reply ##1 s_end_reply;
  endproperty
  a_write_reply: assert property (p_write_reply) else $error("bad write reply tokens");

  property p_write_fail;
    wr_acc && (s_q.wr_lock || cfg_req_reg == REG_DESCRIPTION) |=> s_fail_reply ##1 s_end_reply;
  endproperty
  a_write_fail: assert property (p_write_fail) else $error("refused write not failed");

  property p_desc_read;
    acc && !cfg_req_write && cfg_req_reg == REG_DESCRIPTION |=> s_ok_reply
      ##1 (cfg_rsp_valid && !cfg_rsp_ctrl && cfg_rsp_word == desc_word) ##1 s_end_reply;
  endproperty
  a_desc_read: assert property (p_desc_read) else $error("bad description read");

  property p_route_local;
    pkt_valid && pkt_dest == s_q.node_id |=> route_valid && route_local;
  endproperty
  a_route_local: assert property (p_route_local) else $error("matching packet not local");

  property p_route_top;
    pkt_valid && pkt_dest[15] != s_q.node_id[15]
      |=> !route_local && route_dir == $past(s_q.dirs[63:60]);
  endproperty
  a_route_top: assert property (p_route_top) else $error("bit 15 mismatch wrong direction");

  property p_route_bit0;
    pkt_valid && pkt_dest[15:1] == s_q.node_id[15:1] && pkt_dest[0] != s_q.node_id[0]
      |=> !route_local && route_dir == $past(s_q.dirs[3:0]);
  endproperty
  a_route_bit0: assert property (p_route_bit0) else $error("bit 0 mismatch wrong direction");

  property p_debug_pull;
    s_q.dbg_pull_en && node_in_debug ##1 s_q.dbg_pull_en && node_in_debug |-> debug_n_oe;
  endproperty
  a_debug_pull: assert property (p_debug_pull) else $error("debug wire not pulled");

  property p_trap_gated;
    !s_q.dbg_trap_en |=> !debug_call_trap;
  endproperty
  a_trap_gated: assert property (p_trap_gated) else $error("trap while disabled");

endmodule // node_switch_route_config
`default_nettype wire

// file: node_switch_pkg.sv
// constants for the node switch configuration and routing block
`default_nettype none
package node_switch_pkg;

  // register numbers carried in configuration messages
  localparam logic [15:0] REG_DESCRIPTION = 16'h0001;
  localparam logic [15:0] REG_SWITCH_CFG  = 16'h0004;
  localparam logic [15:0] REG_NODE_ID     = 16'h0005;
  localparam logic [15:0] REG_CLK_MULT    = 16'h0006;
  localparam logic [15:0] REG_DIRS_LOW    = 16'h000C;
  localparam logic [15:0] REG_DIRS_HIGH   = 16'h000D;
  localparam logic [15:0] REG_DEBUG_PIN   = 16'h0010;

  // field positions
  localparam int DESC_LINKS_LSB  = 16;
  localparam int DESC_CORES_LSB  = 8;
  localparam int DESC_LPP_LSB    = 0;
  localparam int CFG_WR_LOCK_BIT = 31;
  localparam int CFG_CM_LOCK_BIT = 8;
  localparam int CFG_HDR_BIT     = 0;
  localparam int DBG_TRAP_BIT    = 1;
  localparam int DBG_PULL_BIT    = 0;
  localparam int NODE_ID_W       = 16;
  localparam int DIR_W           = 4;

  // values after reset
  localparam logic [15:0] NODE_ID_RST  = 16'h0000;
  localparam logic [31:0] DIRS_RST     = 32'h0000_0000;
  localparam logic [31:0] CLK_MULT_RST = 32'h0000_0000;

  // response control tokens
  localparam logic [31:0] TOK_ACK  = 32'h0000_0003;
  localparam logic [31:0] TOK_NACK = 32'h0000_0004;
  localparam logic [31:0] TOK_END  = 32'h0000_0001;

  typedef enum logic [1:0] {RSP_IDLE, RSP_DATA, RSP_END} rsp_state_t;

endpackage : node_switch_pkg
`default_nettype wire

// file: route_lookup_if.sv
// lookup request and answer between the switch top and its route decoder
`default_nettype none
interface route_lookup_if;
  logic [15:0] dest;
  logic [15:0] node_id;
  logic [63:0] dirs;
  logic        local_hit;
  logic [3:0]  dir;

  modport requester (output dest, output node_id, output dirs, input local_hit, input dir);
  modport decoder   (input dest, input node_id, input dirs, output local_hit, output dir);
endinterface : route_lookup_if
`default_nettype wire

// file: route_lookup.sv
// highest mismatching bit picks one direction nibble
`default_nettype none
module route_lookup #(
  parameter int IDW = 16
) (
  route_lookup_if.decoder lk
);
  import node_switch_pkg::*;

  logic [IDW-1:0] diff;

  always_comb
  begin
    diff         = lk.dest ^ lk.node_id;
    lk.dir       = 4'h0;
    lk.local_hit = (diff == '0);
    // last hit is the highest bit
    for (int i = 0; i < IDW; i++)
    begin
      if (diff[i])
      begin
        lk.dir = lk.dirs[i*DIR_W +: DIR_W];
      end
    end
  end

endmodule // route_lookup
`default_nettype wire

// file: cfg_requester_model.sv
// configuration requester standing at the far side of the switch
`default_nettype none
module cfg_requester_model (
  // clock
  input  wire logic        clk,
  // request toward the switch
  output var  logic        valid,
  output var  logic        write,
  output var  logic [15:0] reg_n,
  output var  logic [31:0] wdata,
  input  wire logic        ready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    valid = 1'b0;
    write = 1'b0;
    reg_n = 16'h0000;
    wdata = 32'h0000_0000;
  end
  task automatic send(input logic wr, input logic [15:0] r, input logic [31:0] d);
    while (ready !== 1'b1)
      @(posedge clk);
    valid <= 1'b1;
    write <= wr;
    reg_n <= r;
    wdata <= d;
    @(posedge clk);
    valid <= 1'b0;
    // released lines carry junk so a stale value never matches
    write <= ~wr;
    reg_n <= ~r;
    wdata <= ~d;
    @(posedge clk);
  endtask
endmodule // cfg_requester_model
`default_nettype wire

// file: node_switch_route_config_tb_top.sv
// self-checking bench for the switch configuration and route block
`default_nettype none
module node_switch_route_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import node_switch_pkg::*;
  localparam logic [7:0] LC = 8'h03;
  localparam logic [7:0] CC = 8'h01;
  localparam logic [7:0] LP = 8'h02;
  localparam logic [5:0][15:0] RST_REGS = {REG_NODE_ID, REG_CLK_MULT, REG_DIRS_LOW,
                                           REG_DIRS_HIGH, REG_DEBUG_PIN, REG_SWITCH_CFG};
  logic        clk, rst, cfg_req_valid, cfg_req_write, cfg_req_ready;
  logic        cfg_rsp_valid, cfg_rsp_ctrl, pkt_valid, route_valid, route_local;
  logic        one_byte_header, tile_reset, node_in_debug, debug_n_i, debug_n_o;
  logic        debug_n_oe, debug_call_trap, ext_low;
  logic [15:0] cfg_req_reg, pkt_dest, dst;
  logic [31:0] cfg_req_wdata, cfg_rsp_word, clk_mult_setting, id, cm;
  logic [63:0] dirs;
  logic [3:0]  route_dir;
  logic [32:0] rsp_q[$];
  logic [4:0]  rt_q[$];
  int          err_count, num_checks, tr_cnt, trap_cnt;

  node_switch_route_config #(.LINK_COUNT(LC), .CORE_COUNT(CC), .LINKS_PER_CORE(LP)) uut (
    .clk, .rst, .cfg_req_valid, .cfg_req_write, .cfg_req_reg, .cfg_req_wdata,
    .cfg_req_ready, .cfg_rsp_valid, .cfg_rsp_ctrl, .cfg_rsp_word, .pkt_valid,
    .pkt_dest, .route_valid, .route_local, .route_dir, .one_byte_header,
    .clk_mult_setting, .tile_reset, .node_in_debug, .debug_n_i, .debug_n_o,
    .debug_n_oe, .debug_call_trap);
  cfg_requester_model requester (.clk(clk), .valid(cfg_req_valid), .write(cfg_req_write),
    .reg_n(cfg_req_reg), .wdata(cfg_req_wdata), .ready(cfg_req_ready));

  // open-drain pin with pull-up
  assign debug_n_i = !ext_low && !(debug_n_oe && !debug_n_o);

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (err_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic req(input logic wr, input logic [15:0] r, input logic [31:0] d,
                     input logic ok, input logic [31:0] rd);
    rsp_q.push_back({1'b1, ok ? TOK_ACK : TOK_NACK});
    if (!wr && ok)
      rsp_q.push_back({1'b0, rd});
    rsp_q.push_back({1'b1, TOK_END});
    requester.send(wr, r, d);
    check({32'h0, cfg_req_ready}, 33'h0);
    while (cfg_req_ready !== 1'b1)
      @(posedge clk);
    @(posedge clk);
  endtask

  // monitor: oldest note against each result
  always @(posedge clk)
  begin
    if (cfg_rsp_valid === 1'b1)
      check({cfg_rsp_ctrl, cfg_rsp_word}, rsp_q.size() ? rsp_q.pop_front() : 'x);
    if (route_valid === 1'b1)
      check({route_local, route_dir}, rt_q.size() ? rt_q.pop_front() : 'x);
    if (tile_reset === 1'b1)
      tr_cnt++;
    if (debug_call_trap === 1'b1)
      trap_cnt++;
  end

  initial
  begin
    repeat (4000) @(posedge clk);
    err_count++;
    end_of_test();
  end

  initial
  begin
    void'($urandom(32'h1B3C));
    rst = 1'b1;
    pkt_valid = 1'b0;
    pkt_dest = 16'h0000;
    node_in_debug = 1'b0;
    ext_low = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    req(1'b0, REG_DESCRIPTION, 32'h0, 1'b1, {8'h00, LC, CC, LP});
    req(1'b1, REG_DESCRIPTION, 32'h0, 1'b0, 32'h0);
    req(1'b0, 16'h0020, 32'h0, 1'b0, 32'h0);
    req(1'b1, 16'h0020, 32'h0, 1'b0, 32'h0);
    for (int i = 0; i < 6; i++)
      req(1'b0, RST_REGS[i], 32'h0, 1'b1, 32'h0);
    // trap disabled at reset
    ext_low <= 1'b1;
    repeat (8) @(posedge clk);
    ext_low <= 1'b0;
    repeat (8) @(posedge clk);
    check(33'(trap_cnt), 33'h0);
    id = $urandom;
    req(1'b1, REG_NODE_ID, id, 1'b1, 32'h0);
    req(1'b0, REG_NODE_ID, 32'h0, 1'b1, {16'h0000, id[15:0]});
    dirs = {$urandom, $urandom};
    req(1'b1, REG_DIRS_LOW, dirs[31:0], 1'b1, 32'h0);
    req(1'b1, REG_DIRS_HIGH, dirs[63:32], 1'b1, 32'h0);
    req(1'b0, REG_DIRS_HIGH, 32'h0, 1'b1, dirs[63:32]);
    // back-to-back packets, one per mismatch position, then local
    for (int b = 0; b < 17; b++)
    begin
      dst = (b == 16) ? id[15:0] : id[15:0] ^ (16'h0001 << b)
            ^ (16'($urandom) & ((16'h0001 << b) - 16'h0001));
      pkt_valid <= 1'b1;
      pkt_dest <= dst;
      rt_q.push_back((b == 16) ? 5'h10 : {1'b0, dirs[b*4 +: 4]});
      @(posedge clk);
    end
    pkt_valid <= 1'b0;
    cm = $urandom;
    req(1'b1, REG_CLK_MULT, cm, 1'b1, 32'h0);
    check({1'b0, clk_mult_setting}, {1'b0, cm});
    check(33'(tr_cnt), 33'h1);
    req(1'b1, REG_SWITCH_CFG, 32'h0000_0101, 1'b1, 32'h0);
    check({32'h0, one_byte_header}, 33'h1);
    req(1'b1, REG_CLK_MULT, ~cm, 1'b0, 32'h0);
    check({1'b0, clk_mult_setting}, {1'b0, cm});
    check(33'(tr_cnt), 33'h1);
    req(1'b1, REG_DEBUG_PIN, 32'hFFFF_FFFF, 1'b1, 32'h0);
    req(1'b0, REG_DEBUG_PIN, 32'h0, 1'b1, 32'h0000_0003);
    ext_low <= 1'b1;
    repeat (8) @(posedge clk);
    ext_low <= 1'b0;
    repeat (8) @(posedge clk);
    check(33'(trap_cnt), 33'h1);
    node_in_debug <= 1'b1;
    repeat (3) @(posedge clk);
    check({31'h0, debug_n_oe, debug_n_o}, 33'h2);
    node_in_debug <= 1'b0;
    req(1'b1, REG_SWITCH_CFG, 32'h8000_0101, 1'b1, 32'h0);
    req(1'b1, REG_NODE_ID, ~id, 1'b0, 32'h0);
    req(1'b0, REG_NODE_ID, 32'h0, 1'b1, {16'h0000, id[15:0]});
    // second reset mid-run clears the locks
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    req(1'b0, REG_SWITCH_CFG, 32'h0, 1'b1, 32'h0);
    check({32'h0, one_byte_header}, 33'h0);
    repeat (10) @(posedge clk);
    check(33'(rsp_q.size() + rt_q.size()), 33'h0);
    end_of_test();
  end
endmodule // node_switch_route_config_tb_top
`default_nettype wire
